// File: core/rtc_defines.vh
// constants for the rtc status flags and time counters
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH
// register addresses
`define ADDR_SECONDS 4'h0
`define ADDR_MINUTES 4'h1
`define ADDR_HOURS 4'h2
`define ADDR_WEEKDAY 4'h3
`define ADDR_CTRL1 4'hE
`define ADDR_STATUS 4'hF
// status_flags_control bit positions
`define ST_THRESH 7
`define ST_SUPPLY_LOW 6
`define ST_OSC_OK 5
`define ST_POWER_UP 4
`define ST_CLK_DIS_A 3
`define ST_PERIODIC 2
`define ST_WEEKLY 1
`define ST_DAILY 0
// control register 1 bit positions
`define C1_WEEKLY_EN 7
`define C1_DAILY_EN 6
`define C1_MODE24 5
`define C1_CLK_DIS_B 4
`define C1_PERIOD_LSB 0
// field masks and values
`define MASK_SEC 8'h7F
`define MASK_HOUR 8'h3F
`define MASK_WDAY 8'h07
`define MASK_CTRL1 8'hF7
`define BCD_59 8'h59
`define BCD_09 4'h9
`define BCD_00 8'h00
`define HOUR_23 8'h23
`define HOUR_PM11 8'h31
`define HOUR_AM11 8'h11
`define HOUR_AM12 8'h12
`define HOUR_PM12 8'h32
`define HOUR_PM1 8'h21
`define HOUR_AM1 8'h01
`define WDAY_LAST 3'h6
// time figures
`define CRYSTAL_HZ 32768
`define CLOCK_HZ 10000000
`define ALARM_DELAY_NS 61000
`define CLOCK_PERIOD_NS 100
// periodic modes: top bit marks level mode
`define PER_OFF 3'h0
`define PER_LOW 3'h1
`define PER_2HZ 3'h2
`define PER_1HZ 3'h3
`define PER_SEC 3'h4
`define PER_MIN 3'h5
`define PER_HOUR 3'h6
`endif

// File: core/rtc_core.v
// rtc status flags, control bits and seconds/minutes/hours/weekday counters
`timescale 1ns/1ps
`include "rtc_defines.vh"

//
// Operation
// - once supply-low is set, monitor stops and flag holds 1
// - writing 0 clears supply-low and restarts monitor; 1 does nothing
// - oscillator halt clears oscillation-ok; it stays 0 until rewritten
// - oscillation-ok reads back and stores written 0 or 1
// - power-up flag sets on supply ramp from zero, holds until cleared
// - power-up flag forces control bits except osc-ok and itself to 0
// - power-up flag clears only by writing 0; writing 1 ignored
// - clock out runs unless both clock-out disable bits are 1
// - periodic flag reads 1 while periodic interrupt drives pin low
// - level mode: writing 0 releases pin until next cycle; 1 ignored
// - enabled alarm flag sets about 61 us after time match
// - writing 0 clears alarm flag, releasing pin until next match
// - alarm flag reads 0 while its enable is 0
// - seconds count bcd 00..59, carry to minutes on wrap
// - minutes count bcd 00..59, carry to hours on wrap
// - hours give day carry at pm11->am12 or 23->00
// - any seconds write resets sub-second prescaler
// - weekday counts 0..6 on day carry, then wraps to 0
// - weekday values carry no fixed meaning in the device
// - mode bit 0 gives 12-hour with pm bit 5; 1 gives 24-hour
module rtc_core #(
    parameter PRESCALE = 15 // sub-second divider stages
) (
    input wire clock, // 10 mhz system clock
    input wire rst, // synchronous reset, high
    input wire crystal_clk, // 32.768 khz crystal clock
    input wire power_on_event, // supply ramped up from zero
    input wire supply_low_det, // supply below threshold
    input wire osc_halt_det, // oscillator halt sensed
    input wire weekly_match, // weekly alarm compare hit
    input wire daily_match, // daily alarm compare hit
    input wire wr_en, // register write strobe
    input wire [3:0] wr_addr, // register write address
    input wire [7:0] wr_data, // register write data
    input wire [3:0] rd_addr, // register read address
    output reg [7:0] rd_data, // registered read data
    output reg irq_pin_n, // interrupt pin, low active
    output reg crystal_clock_out, // gated 32 khz output
    output reg supply_threshold_select, // monitor threshold select
    output reg supply_monitor_on, // monitor running
    output reg day_carry // one-cycle day carry pulse
);

    localparam integer ALARM_CYC =
        (`ALARM_DELAY_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS;
    localparam [9:0] ALARM_CYC_W = ALARM_CYC[9:0];

    // ************************************************************
    // input synchronisers
    // ************************************************************
    reg [5:0] sync1_q;
    reg [5:0] sync2_q;
    reg xtal_prev_q;
    // two flops on each of the six sensed inputs; the host port is not synchronised
    always @(posedge clock) begin
        if (rst) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
            xtal_prev_q <= 1'b0;
        end else begin
            sync1_q <= {crystal_clk, power_on_event, supply_low_det,
                        osc_halt_det, weekly_match, daily_match};
            sync2_q <= sync1_q;
            xtal_prev_q <= sync2_q[5];
        end
    end
    wire xtal_s = sync2_q[5];
    wire pon_s = sync2_q[4];
    wire low_s = sync2_q[3];
    wire halt_s = sync2_q[2];
    wire wmatch_s = sync2_q[1];
    wire dmatch_s = sync2_q[0];
    wire xtal_tick = xtal_s & ~xtal_prev_q;

    // ************************************************************
    // registers and write decode
    // ************************************************************
    reg [6:0] sec_q;
    reg [6:0] min_q;
    reg [5:0] hour_q;
    reg [2:0] wday_q;
    reg [7:0] ctrl1_q;
    reg thresh_q, low_q, osc_ok_q, pon_q, dis_a_q;
    reg per_q, wflag_q, dflag_q;
    reg [PRESCALE-1:0] presc_q;
    reg wm_prev_q, dm_prev_q;
    reg [9:0] wdly_q, ddly_q;
    reg per_prev_q;
    wire wr_sec = wr_en & (wr_addr == `ADDR_SECONDS);
    wire wr_min = wr_en & (wr_addr == `ADDR_MINUTES);
    wire wr_hour = wr_en & (wr_addr == `ADDR_HOURS);
    wire wr_wday = wr_en & (wr_addr == `ADDR_WEEKDAY);
    wire wr_c1 = wr_en & (wr_addr == `ADDR_CTRL1);
    wire wr_st = wr_en & (wr_addr == `ADDR_STATUS);
    wire mode24 = ctrl1_q[`C1_MODE24];
    wire [2:0] per_mode = ctrl1_q[2:0];
    wire per_level = per_mode[2];

    // ************************************************************
    // prescaler and time counters
    // ************************************************************
    wire sec_tick = xtal_tick & (&presc_q);
    wire half_bit = presc_q[PRESCALE-1];
    wire sec_wrap = (sec_q == `BCD_59);
    wire min_wrap = (min_q == `BCD_59);
    wire [7:0] hour8 = {2'b00, hour_q};
    wire hour_wrap = mode24 ? (hour8 == `HOUR_23)
                            : (hour8 == `HOUR_PM11);
    wire min_carry = sec_tick & sec_wrap;
    wire hour_carry = min_carry & min_wrap;
    wire day_c = hour_carry & hour_wrap;

    // bcd increment of a 7-bit two-digit field
    function [6:0] bcd_inc;
        input [6:0] v;
        begin
            if (v[3:0] == `BCD_09)
                bcd_inc = {v[6:4] + 3'h1, 4'h0};
            else
                bcd_inc = {v[6:4], v[3:0] + 4'h1};
        end
    endfunction

    // next hour in 12 or 24 hour coding
    reg [7:0] hour_next;
    always @* begin
        hour_next = {1'b0, bcd_inc({1'b0, hour_q})};
        if (hour_wrap)
            hour_next = `BCD_00;
        if (!mode24) begin
            if (hour8 == `HOUR_AM11)
                hour_next = `HOUR_PM12; // noon turns the pm bit on
            else if (hour8 == `HOUR_AM12)
                hour_next = `HOUR_AM1;
            else if (hour8 == `HOUR_PM11)
                hour_next = `HOUR_AM12;
            else if (hour8 == `HOUR_PM12)
                hour_next = `HOUR_PM1;
        end
    end

    // counters; host write overrides the count
    always @(posedge clock) begin
        if (rst) begin
            presc_q <= {PRESCALE{1'b0}};
            sec_q <= 7'h00;
            min_q <= 7'h00;
            hour_q <= 6'h12;
            wday_q <= 3'h0;
        end else begin
            if (wr_sec)
                presc_q <= {PRESCALE{1'b0}};
            else if (xtal_tick)
                presc_q <= presc_q + 1'b1;
            if (wr_sec)
                sec_q <= wr_data[6:0];
            else if (sec_tick)
                sec_q <= sec_wrap ? 7'h00 : bcd_inc(sec_q);
            if (wr_min)
                min_q <= wr_data[6:0];
            else if (min_carry)
                min_q <= min_wrap ? 7'h00 : bcd_inc(min_q);
            if (wr_hour)
                hour_q <= wr_data[5:0];
            else if (hour_carry)
                hour_q <= hour_next[5:0];
            if (wr_wday)
                wday_q <= wr_data[2:0];
            else if (day_c)
                wday_q <= (wday_q == `WDAY_LAST) ? 3'h0
                                                 : wday_q + 3'h1;
        end
    end

    // ************************************************************
    // periodic interrupt source
    // ************************************************************
    reg per_src;
    always @* begin
        case (per_mode)
            `PER_OFF: per_src = 1'b0;
            `PER_LOW: per_src = 1'b1;
            `PER_2HZ: per_src = presc_q[PRESCALE-2];
            `PER_1HZ: per_src = half_bit;
            `PER_SEC: per_src = sec_tick;
            `PER_MIN: per_src = min_carry;
            `PER_HOUR: per_src = hour_carry;
            default: per_src = day_c;
        endcase
    end
    wire pulse_mode = ~per_level;
    wire per_set = per_level & per_src & ~per_prev_q;

    // ************************************************************
    // status flags and control registers
    // ************************************************************
    wire wm_set = (wdly_q == ALARM_CYC_W);
    wire dm_set = (ddly_q == ALARM_CYC_W);
    always @(posedge clock) begin
        if (rst) begin
            ctrl1_q <= 8'h00;
            thresh_q <= 1'b0;
            low_q <= 1'b0;
            osc_ok_q <= 1'b0;
            pon_q <= 1'b1;
            dis_a_q <= 1'b0;
            per_q <= 1'b0;
            wflag_q <= 1'b0;
            dflag_q <= 1'b0;
            wm_prev_q <= 1'b0;
            dm_prev_q <= 1'b0;
            wdly_q <= 10'h000;
            ddly_q <= 10'h000;
            per_prev_q <= 1'b0;
        end else begin
            wm_prev_q <= wmatch_s;
            dm_prev_q <= dmatch_s;
            per_prev_q <= per_src;
            // alarm delay timers start on a rising match
            if (wmatch_s & ~wm_prev_q)
                wdly_q <= 10'h001;
            else if (wdly_q != 10'h000 && !wm_set)
                wdly_q <= wdly_q + 10'h001;
            else
                wdly_q <= 10'h000;
            if (dmatch_s & ~dm_prev_q)
                ddly_q <= 10'h001;
            else if (ddly_q != 10'h000 && !dm_set)
                ddly_q <= ddly_q + 10'h001;
            else
                ddly_q <= 10'h000;
            if (wr_c1)
                ctrl1_q <= wr_data & `MASK_CTRL1;
            if (wr_st) begin
                thresh_q <= wr_data[`ST_THRESH];
                dis_a_q <= wr_data[`ST_CLK_DIS_A];
                osc_ok_q <= wr_data[`ST_OSC_OK];
                if (!wr_data[`ST_SUPPLY_LOW])
                    low_q <= 1'b0;
                if (!wr_data[`ST_POWER_UP])
                    pon_q <= 1'b0;
                if (!wr_data[`ST_PERIODIC] && per_level)
                    per_q <= 1'b0;
                if (!wr_data[`ST_WEEKLY])
                    wflag_q <= 1'b0;
                if (!wr_data[`ST_DAILY])
                    dflag_q <= 1'b0;
            end
            // set conditions follow the host writes so they win over them
            if (low_s & ~low_q)
                low_q <= 1'b1;
            if (halt_s)
                osc_ok_q <= 1'b0;
            if (per_set)
                per_q <= 1'b1;
            if (wm_set & ctrl1_q[`C1_WEEKLY_EN])
                wflag_q <= 1'b1;
            if (dm_set & ctrl1_q[`C1_DAILY_EN])
                dflag_q <= 1'b1;
            if (!ctrl1_q[`C1_WEEKLY_EN])
                wflag_q <= 1'b0;
            if (!ctrl1_q[`C1_DAILY_EN])
                dflag_q <= 1'b0;
            if (pon_s)
                pon_q <= 1'b1;
            // power-up forces control bits clear
            if (pon_q | pon_s) begin
                ctrl1_q <= 8'h00;
                thresh_q <= 1'b0;
                low_q <= 1'b0;
                dis_a_q <= 1'b0;
                per_q <= 1'b0;
                wflag_q <= 1'b0;
                dflag_q <= 1'b0;
            end
        end
    end

    // pulse-mode flag follows the pin level directly
    wire per_low = pulse_mode ? (per_mode == `PER_LOW) |
        ((per_mode != `PER_OFF) & ~per_src) : per_q;
    wire [7:0] status_rd = {thresh_q, low_q, osc_ok_q, pon_q, dis_a_q,
                            per_low, wflag_q, dflag_q};

    // ************************************************************
    // read data and pins
    // ************************************************************
    always @(posedge clock) begin
        if (rst) begin
            rd_data <= 8'h00;
            irq_pin_n <= 1'b1;
            crystal_clock_out <= 1'b1;
            supply_threshold_select <= 1'b0;
            supply_monitor_on <= 1'b1;
            day_carry <= 1'b0;
        end else begin
            case (rd_addr)
                `ADDR_SECONDS: rd_data <= {1'b0, sec_q};
                `ADDR_MINUTES: rd_data <= {1'b0, min_q};
                `ADDR_HOURS: rd_data <= {2'b00, hour_q};
                `ADDR_WEEKDAY: rd_data <= {5'h00, wday_q};
                `ADDR_CTRL1: rd_data <= ctrl1_q;
                `ADDR_STATUS: rd_data <= status_rd;
                default: rd_data <= 8'h00;
            endcase
            irq_pin_n <= ~(per_low | wflag_q | dflag_q);
            crystal_clock_out <= (dis_a_q & ctrl1_q[`C1_CLK_DIS_B])
                                 ? 1'b1 : xtal_s;
            supply_threshold_select <= thresh_q;
            supply_monitor_on <= ~low_q;
            day_carry <= day_c;
        end
    end

endmodule // rtc_core

// File: tb/rtc_core_asserts.sv
// assertion checker on the rtc core ports
`timescale 1ns/1ps
module rtc_core_chk (
    input wire clock, // system clock
    input wire rst, // sync reset, high
    input wire wr_en, // write strobe
    input wire [3:0] wr_addr, // write address
    input wire [7:0] wr_data, // write data
    input wire [3:0] rd_addr, // read address
    input wire [7:0] rd_data, // read data
    input wire irq_pin_n, // interrupt pin
    input wire crystal_clock_out, // 32 khz out
    input wire supply_low_det, // supply low sense
    input wire power_on_event, // supply ramp sense
    input wire supply_monitor_on, // monitor running
    input wire day_carry // day carry pulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ****************
    // properties
    // ****************
    // host write clearing the supply-low flag
    wire clr_low = wr_en && wr_addr == 4'hF && !wr_data[6];
    AST_SEC_UPPER: assert property (
        $past(rd_addr) == 4'h0 |-> !rd_data[7])
        else $error("seconds upper bit set");
    AST_HOUR_UPPER: assert property (
        $past(rd_addr) == 4'h2 |-> rd_data[7:6] == 2'b00)
        else $error("hours upper bits set");
    AST_WDAY_UPPER: assert property (
        $past(rd_addr) == 4'h3 |-> rd_data[7:3] == 5'h00)
        else $error("weekday upper bits set");
    AST_RESET_VALS: assert property (
        $fell(rst) |-> irq_pin_n && crystal_clock_out
        && !day_carry && rd_data == 8'h00)
        else $error("outputs wrong after reset");
    // a power-up event also clears the supply-low flag
    AST_MON_HOLD: assert property (
        !supply_monitor_on && !clr_low && !$past(clr_low)
        && !$past(clr_low, 2) && !$past(power_on_event, 2)
        |=> !supply_monitor_on)
        else $error("monitor restarted without clear");
    AST_MON_RESTART: assert property (
        !supply_monitor_on && clr_low && !supply_low_det
        |-> ##[1:4] supply_monitor_on)
        else $error("monitor not restarted");
    AST_PUF_FORCE: assert property (
        $past(rd_addr) == 4'hF && rd_data[4]
        |-> rd_data[7:6] == 2'b00 && rd_data[3:0] == 4'h0)
        else $error("status bits not forced by power-up flag");
    AST_CARRY_PULSE: assert property (day_carry |=> !day_carry [*8])
        else $error("day carry longer than one cycle");
    AST_WDAY_STORE: assert property (
        wr_en && wr_addr == 4'h3 && rd_addr == 4'h3 ##1 rd_addr == 4'h3
        |=> rd_data[2:0] == $past(wr_data[2:0], 2))
        else $error("weekday value not stored");
endmodule // rtc_core_chk

bind rtc_core rtc_core_chk i_rtc_core_chk (.clock(clock), .rst(rst),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
    .rd_data(rd_data), .irq_pin_n(irq_pin_n),
    .crystal_clock_out(crystal_clock_out), .supply_low_det(supply_low_det),
    .power_on_event(power_on_event),
    .supply_monitor_on(supply_monitor_on), .day_carry(day_carry));

// File: tb/rtc_host_model.sv
// host model driving the core's register access port
`timescale 1ns/1ps
module rtc_host_model (
    input wire clock, // system clock
    input wire [7:0] rd_data, // read data from core
    output reg wr_en, // write strobe
    output reg [3:0] wr_addr, // write address
    output reg [7:0] wr_data, // write data
    output reg [3:0] rd_addr // read address
);
    // ****************
    // access tasks
    // ****************
    // idle port at time zero
    initial begin
        wr_en = 1'b0;
        wr_addr = 4'h0;
        wr_data = 8'h00;
        rd_addr = 4'h0;
    end
    // one write, held across one rising edge; data sent as given, unchecked
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(negedge clock);
            wr_en = 1'b1;
            wr_addr = a;
            wr_data = d;
            @(negedge clock);
            wr_en = 1'b0;
            wr_data = ~d; // released data must not linger
        end
    endtask
    // address out, data back one edge later
    task rd(input [3:0] a, output [7:0] d);
        begin
            @(negedge clock);
            rd_addr = a;
            @(negedge clock);
            d = rd_data;
        end
    endtask
endmodule // rtc_host_model

// File: tb/rtc_core_bench.sv
// self-checking bench for the rtc core
`timescale 1ns/1ps
module rtc_core_bench;
    reg clock, rst, crystal_clk, power_on_event, supply_low_det;
    reg osc_halt_det, weekly_match, daily_match;
    wire wr_en, irq_pin_n, crystal_clock_out, supply_threshold_select;
    wire supply_monitor_on, day_carry;
    wire [3:0] wr_addr, rd_addr;
    wire [7:0] wr_data, rd_data;
    integer n_fail = 0, checks_done = 0, i, k, n;
    reg [7:0] v;
    rtc_core #(.PRESCALE(4)) i_rtc_core (.clock(clock), .rst(rst),
        .crystal_clk(crystal_clk), .power_on_event(power_on_event),
        .supply_low_det(supply_low_det), .osc_halt_det(osc_halt_det),
        .weekly_match(weekly_match), .daily_match(daily_match),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_addr(rd_addr), .rd_data(rd_data), .irq_pin_n(irq_pin_n),
        .crystal_clock_out(crystal_clock_out),
        .supply_threshold_select(supply_threshold_select),
        .supply_monitor_on(supply_monitor_on), .day_carry(day_carry));
    rtc_host_model i_rtc_host_model (.clock(clock), .rd_data(rd_data),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_addr(rd_addr));
    // ****************
    // clocks and helpers
    // ****************
    // system clock and free-running crystal, unrelated phase
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        crystal_clk = 1'b0;
        #37;
        forever #400 crystal_clk = ~crystal_clk;
    end
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h",
                         $time, seen, exp);
            end
        end
    endtask
    task rchk(input [3:0] a, input [7:0] exp);
        begin
            i_rtc_host_model.rd(a, v);
            chk(v, exp);
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        i_rtc_host_model.wr(a, d);
    endtask
    task cyc(input integer c);
        repeat (c) @(negedge clock);
    endtask
    // bounded wait: sel 1 for interrupt low, 0 for day carry
    task wait_cond(input integer sel, input integer lim);
        begin
            k = 0;
            while (k < lim && (sel != 0 ? irq_pin_n !== 1'b0
                                        : day_carry !== 1'b1)) begin
                @(negedge clock);
                k = k + 1;
            end
        end
    endtask
    // count low cycles of the clock output
    task lows;
        begin
            n = 0;
            repeat (40) begin
                @(negedge clock);
                if (crystal_clock_out === 1'b0) n = n + 1;
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks=%0d failures=%0d", checks_done, n_fail);
            if (n_fail == 0 && checks_done > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // ****************
    // tests
    // ****************
    initial begin
        #3000000;
        n_fail = n_fail + 1;
        finish_test;
    end
    initial begin
        rst = 1'b1;
        {power_on_event, supply_low_det, osc_halt_det} = 3'b000;
        {weekly_match, daily_match} = 2'b00;
        cyc(10);
        rst = 1'b0;
        rchk(4'hF, 8'h10);
        wr(4'hE, 8'hF7);
        rchk(4'hE, 8'h00);
        wr(4'hF, 8'hFF);
        rchk(4'hF, 8'h30);
        wr(4'hF, 8'h00);
        rchk(4'hF, 8'h00);
        wr(4'hF, 8'h20);
        rchk(4'hF, 8'h20);
        osc_halt_det = 1'b1;
        cyc(5);
        osc_halt_det = 1'b0;
        cyc(5);
        rchk(4'hF, 8'h00);
        supply_low_det = 1'b1;
        cyc(5);
        supply_low_det = 1'b0;
        cyc(10);
        rchk(4'hF, 8'h40);
        chk({7'h0, supply_monitor_on}, 8'h00);
        wr(4'hF, 8'h40);
        rchk(4'hF, 8'h40);
        wr(4'hF, 8'h00);
        cyc(3);
        chk({7'h0, supply_monitor_on}, 8'h01);
        for (i = 0; i < 3; i = i + 1) begin
            wr(4'hE, i == 2 ? 8'h00 : 8'h10);
            wr(4'hF, i == 1 ? 8'h00 : 8'h08);
            cyc(3);
            lows;
            chk({7'h0, n != 0}, {7'h0, i != 0});
        end
        wr(4'hF, 8'h00);
        wr(4'hE, 8'h20);
        rchk(4'h3, 8'h00);
        wr(4'h3, 8'hFE);
        rchk(4'h3, 8'h06);
        wr(4'h2, 8'hE3);
        wr(4'h1, 8'hD9);
        wr(4'h0, 8'hD9);
        cyc(100);
        rchk(4'h0, 8'h59);
        wait_cond(0, 200);
        chk({7'h0, day_carry}, 8'h01);
        cyc(2);
        rchk(4'h0, 8'h00);
        rchk(4'h1, 8'h00);
        rchk(4'h2, 8'h00);
        rchk(4'h3, 8'h00);
        wr(4'hE, 8'h00);
        wr(4'h2, 8'h31);
        wr(4'h1, 8'h59);
        wr(4'h0, 8'h59);
        wait_cond(0, 300);
        chk({7'h0, day_carry}, 8'h01);
        cyc(2);
        rchk(4'h2, 8'h12);
        rchk(4'h3, 8'h01);
        wr(4'h2, 8'h11);
        wr(4'h1, 8'h59);
        wr(4'h0, 8'h59);
        cyc(140);
        rchk(4'h2, 8'h32);
        wr(4'hE, 8'h04);
        wait_cond(1, 300);
        rchk(4'hF, 8'h04);
        wr(4'hF, 8'h04);
        cyc(2);
        chk({7'h0, irq_pin_n}, 8'h00);
        wr(4'hF, 8'h00);
        cyc(2);
        chk({7'h0, irq_pin_n}, 8'h01);
        wr(4'hE, 8'h01);
        cyc(2);
        chk({7'h0, irq_pin_n}, 8'h00);
        rchk(4'hF, 8'h04);
        wr(4'hE, 8'h80);
        {weekly_match, daily_match} = 2'b11;
        cyc(600);
        chk({7'h0, irq_pin_n}, 8'h01);
        wait_cond(1, 40);
        chk({7'h0, irq_pin_n}, 8'h00);
        {weekly_match, daily_match} = 2'b00;
        rchk(4'hF, 8'h02);
        wr(4'hF, 8'h03);
        rchk(4'hF, 8'h02);
        wr(4'hF, 8'h80);
        cyc(2);
        chk({7'h0, irq_pin_n}, 8'h01);
        chk({7'h0, supply_threshold_select}, 8'h01);
        wr(4'hE, 8'h40);
        rchk(4'hF, 8'h80);
        power_on_event = 1'b1;
        cyc(5);
        power_on_event = 1'b0;
        cyc(5);
        rchk(4'hF, 8'h10);
        rchk(4'hE, 8'h00);
        chk({7'h0, supply_threshold_select}, 8'h00);
        finish_test;
    end
endmodule // rtc_core_bench
